// ---- gapc_defines.vh ----
// Register map, field positions and reset values of the pin control block
`ifndef GAPC_DEFINES_VH
`define GAPC_DEFINES_VH
`define GAPC_ADDR_W 4
`define GAPC_ADDR_PIN 4'h0
`define GAPC_ADDR_FLAG 4'h1
`define GAPC_ADDR_IRQ_STAT 4'h2
`define GAPC_ADDR_IRQ_MASK 4'h3
`define GAPC_PIN_RESET 16'hFFFF
`define GAPC_PIN_FIXED_ONES 16'hF0C0
`define GAPC_LEVEL_LSB 0
`define GAPC_FUNC_LSB 8
`define GAPC_FLAG_LSB 8
`define GAPC_NUM_PINS 6
`define GAPC_NUM_ALARM 4
`endif

// ---- gapc_ext_dev.sv ----
// Pull-ups and peer devices on the six pins
`timescale 1ns/1ps
module gapc_ext_dev (
   // Drive enables
   input wire [5:0] oe_i,
   input wire [5:0] peer_low_i,
   // Wire level
   output wire [5:0] lvl_o
);
   // Pull-up unless pulled low
   assign lvl_o = ~(oe_i | peer_low_i);
endmodule

// ---- gapc_pin_ctrl.v ----
// Six open-drain pins with general I/O function, pins 0-3 also selectable as alarm indicators
`timescale 1ns/1ps
`include "gapc_defines.vh"
module gapc_pin_ctrl #(
   parameter NPINS = `GAPC_NUM_PINS,
   parameter NALARM = `GAPC_NUM_ALARM
)(
   // Clock and reset
   input wire ref_clk_i,
   input wire sys_rst_i,
   // Register port
   input wire [`GAPC_ADDR_W-1:0] reg_addr_i,
   input wire [15:0] reg_wdata_i,
   input wire reg_wr_i,
   input wire reg_rd_i,
   output wire [15:0] reg_rdata_o,
   // Out-of-range flags from threshold logic
   input wire [NALARM-1:0] out_of_range_flag_i,
   // Open-drain pins
   input wire [NPINS-1:0] pin_i,
   output wire [NPINS-1:0] pin_o,
   output wire [NPINS-1:0] pin_oe_o,
   // Interrupt
   output wire irq_o
);
   // Reset image and fixed-one mask
   localparam [15:0] PIN_RST = `GAPC_PIN_RESET;
   localparam [15:0] PIN_FIXED = `GAPC_PIN_FIXED_ONES;
   localparam [15:0] ZERO16 = 16'h0000;

   // Control register fields
   reg [NPINS-1:0] pin_level_bit_ff;
   reg [NALARM-1:0] pin_function_select_ff;
   // Pin output flops
   reg [NPINS-1:0] oe_ff;
   reg [NPINS-1:0] drive_ff;
   // Read port
   reg [15:0] rdata_ff;
   reg [15:0] nxt_rdata;
   // Interrupt state
   reg [NALARM-1:0] flag_q_ff;
   reg [NALARM-1:0] irq_stat_ff;
   reg [NALARM-1:0] irq_mask_ff;
   reg irq_ff;
   reg [NALARM-1:0] nxt_irq_stat;
   reg [NALARM-1:0] nxt_irq_mask;
   reg nxt_irq;
   // Internal nets
   wire [NPINS-1:0] nxt_oe;
   wire [NPINS-1:0] pin_sync;
   wire [NALARM-1:0] alarm_rise;
   wire [15:0] pin_reg_view;
   wire [15:0] flag_view;
   wire [15:0] stat_view;
   wire [15:0] mask_view;
   wire wr_pin;
   wire wr_mask;
   wire rd_stat;
   genvar g;

   ////////////////////////////////////////////////////////////
   // Pin input synchroniser
   gapc_sync3 #(
      .W(NPINS)
   ) u_sync (
      .ref_clk_i(ref_clk_i),
      .sys_rst_i(sys_rst_i),
      .async_i(pin_i),
      .sync_o(pin_sync)
   );

   ////////////////////////////////////////////////////////////
   // Control register
   assign wr_pin = reg_wr_i && (reg_addr_i == `GAPC_ADDR_PIN);

   always @(posedge ref_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         pin_level_bit_ff <= PIN_RST[`GAPC_LEVEL_LSB +: NPINS];
         pin_function_select_ff <= PIN_RST[`GAPC_FUNC_LSB +: NALARM];
      end
      else if (wr_pin)
      begin
         pin_level_bit_ff <= reg_wdata_i[`GAPC_LEVEL_LSB +: NPINS];
         pin_function_select_ff <= reg_wdata_i[`GAPC_FUNC_LSB +: NALARM];
      end
   end

   ////////////////////////////////////////////////////////////
   // Pin drive selection, one slice per pin
   generate
      for (g = 0; g < NPINS; g = g + 1)
      begin : g_pin
         if (g < NALARM)
         begin : g_dual
            wire ind_mode;
            wire ind_drive;
            wire io_drive;
            assign ind_mode = ~pin_function_select_ff[g];
            assign ind_drive = out_of_range_flag_i[g];
            assign io_drive = ~pin_level_bit_ff[g];
            assign nxt_oe[g] = ind_mode ? ind_drive : io_drive;
         end
         else
         begin : g_io
            wire io_drive;
            assign io_drive = ~pin_level_bit_ff[g];
            assign nxt_oe[g] = io_drive;
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////
   // Pin output flops
   always @(posedge ref_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         oe_ff <= {NPINS{1'b0}};
         drive_ff <= {NPINS{1'b0}};
      end
      else
      begin
         oe_ff <= nxt_oe;
         // Open drain: driven value is always low
         drive_ff <= {NPINS{1'b0}};
      end
   end

   ////////////////////////////////////////////////////////////
   // Alarm interrupt
   assign alarm_rise = out_of_range_flag_i & ~flag_q_ff;
   assign rd_stat = reg_rd_i && (reg_addr_i == `GAPC_ADDR_IRQ_STAT);
   assign wr_mask = reg_wr_i && (reg_addr_i == `GAPC_ADDR_IRQ_MASK);

   always @*
   begin
      // New event wins over read clear
      nxt_irq_stat = (rd_stat ? {NALARM{1'b0}} : irq_stat_ff) | alarm_rise;
      nxt_irq_mask = wr_mask ? reg_wdata_i[NALARM-1:0] : irq_mask_ff;
      nxt_irq = |(nxt_irq_stat & nxt_irq_mask);
   end

   // Level output follows the masked status
   always @(posedge ref_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         flag_q_ff <= {NALARM{1'b0}};
         irq_stat_ff <= {NALARM{1'b0}};
         irq_mask_ff <= {NALARM{1'b0}};
         irq_ff <= 1'b0;
      end
      else
      begin
         flag_q_ff <= out_of_range_flag_i;
         irq_stat_ff <= nxt_irq_stat;
         irq_mask_ff <= nxt_irq_mask;
         irq_ff <= nxt_irq;
      end
   end

   ////////////////////////////////////////////////////////////
   // Register views
   // Pin levels, function selects and fixed ones on read
   assign pin_reg_view = PIN_FIXED
                       | ({{(16-NALARM){1'b0}}, pin_function_select_ff} << `GAPC_FUNC_LSB)
                       | ({{(16-NPINS){1'b0}}, pin_sync} << `GAPC_LEVEL_LSB);
   assign flag_view = {{(16-NALARM){1'b0}}, out_of_range_flag_i} << `GAPC_FLAG_LSB;
   assign stat_view = {{(16-NALARM){1'b0}}, irq_stat_ff};
   assign mask_view = {{(16-NALARM){1'b0}}, irq_mask_ff};

   ////////////////////////////////////////////////////////////
   // Read data
   always @*
   begin
      nxt_rdata = ZERO16;
      case (reg_addr_i)
         `GAPC_ADDR_PIN: nxt_rdata = pin_reg_view;
         `GAPC_ADDR_FLAG: nxt_rdata = flag_view;
         `GAPC_ADDR_IRQ_STAT: nxt_rdata = stat_view;
         `GAPC_ADDR_IRQ_MASK: nxt_rdata = mask_view;
         // Unmapped indices read zero
         default: nxt_rdata = ZERO16;
      endcase
   end

   always @(posedge ref_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         rdata_ff <= ZERO16;
      else if (reg_rd_i)
         rdata_ff <= nxt_rdata;
      else
         // Data stands one cycle only
         rdata_ff <= ZERO16;
   end

   ////////////////////////////////////////////////////////////
   // Outputs
   assign reg_rdata_o = rdata_ff;
   assign pin_o = drive_ff;
   assign pin_oe_o = oe_ff;
   assign irq_o = irq_ff;
endmodule

// ---- gapc_pin_ctrl_properties.sv ----
// Port assertions for the pin control block
`timescale 1ns/1ps
module gapc_chk #(parameter NPINS = 6, parameter NALARM = 4)(
   // Watched ports
   input wire ref_clk_i,
   input wire sys_rst_i,
   input wire [3:0] reg_addr_i,
   input wire [15:0] reg_wdata_i,
   input wire reg_wr_i,
   input wire reg_rd_i,
   input wire [15:0] reg_rdata_o,
   input wire [NALARM-1:0] out_of_range_flag_i,
   input wire [NPINS-1:0] pin_i,
   input wire [NPINS-1:0] pin_o,
   input wire [NPINS-1:0] pin_oe_o,
   input wire irq_o
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (sys_rst_i);
   wire pin_wr = reg_wr_i && reg_addr_i == 4'h0;
   sequence quiet_pins;
      $stable(pin_i) [*6];
   endsequence
   AST_OD: assert property (pin_o == 6'h00)
      else $error("pin value not low");
   AST_RST: assert property ($fell(sys_rst_i) |-> pin_oe_o == 6'h00)
      else $error("pin driven after reset");
   AST_FIX: assert property (reg_rd_i && reg_addr_i == 4'h0 |=> (reg_rdata_o & 16'hF0C0) == 16'hF0C0)
      else $error("fixed bits not one");
   AST_LVL: assert property (pin_wr && reg_wdata_i[11:8] == 4'hF |-> ##2 pin_oe_o == ~$past(reg_wdata_i[5:0], 2))
      else $error("level bit drive wrong");
   AST_IND: assert property (pin_wr && reg_wdata_i[11:8] == 4'h0 |-> ##2 pin_oe_o[3:0] == $past(out_of_range_flag_i))
      else $error("indicator drive wrong");
   AST_IO: assert property (pin_wr |-> ##2 pin_oe_o[5:4] == ~$past(reg_wdata_i[5:4], 2))
      else $error("upper pins not plain io");
   AST_HOLD: assert property (!$past(reg_wr_i) && $stable(out_of_range_flag_i) |=> $stable(pin_oe_o))
      else $error("drive moved without cause");
   AST_SENSE: assert property (quiet_pins ##0 reg_rd_i && reg_addr_i == 4'h0 |=> reg_rdata_o[5:0] == $past(pin_i))
      else $error("read level wrong");
endmodule
bind gapc_pin_ctrl gapc_chk #(.NPINS(NPINS), .NALARM(NALARM)) u_chk (.*);

// ---- gapc_pin_ctrl_tb.sv ----
// Self-checking bench for the pin control block
`timescale 1ns/1ps
module gapc_pin_ctrl_tb;
   reg ref_clk_i = 0, sys_rst_i = 1, wr = 0, rd = 0;
   reg [3:0] addr = 0, flg = 0;
   reg [15:0] wd = 0, v, ctl, e;
   reg [5:0] peer = 0, xoe;
   reg [31:0] r;
   wire [15:0] rdata;
   wire [5:0] oe, lvl, po;
   wire irq;
   integer seed = 32'h2782502d, error_cnt = 0, n_compared = 0, i, k;
   always #25 ref_clk_i = ~ref_clk_i;
   gapc_pin_ctrl uut (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(addr),
      .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
      .out_of_range_flag_i(flg), .pin_i(lvl), .pin_o(po), .pin_oe_o(oe), .irq_o(irq));
   gapc_ext_dev peer_dev (.oe_i(oe), .peer_low_i(peer), .lvl_o(lvl));
   task chk(input [15:0] s, input [15:0] x);
   begin
      n_compared = n_compared + 1;
      if (s !== x)
      begin
         error_cnt = error_cnt + 1;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, x);
      end
   end
   endtask
   task bus(input w, input [3:0] a, input [15:0] d);
   begin
      @(posedge ref_clk_i);
      addr <= a;
      wd <= d;
      wr <= w;
      rd <= !w;
      @(posedge ref_clk_i);
      wr <= 0;
      rd <= 0;
      @(negedge ref_clk_i);
      v = rdata;
   end
   endtask
   function [5:0] xp(input [15:0] c, input [3:0] f);
      for (k = 0; k < 6; k = k + 1)
         xp[k] = (k < 4 && !c[8+k]) ? f[k] : !c[k];
   endfunction
   task test_done;
   begin
      $display("errors %0d compared %0d", error_cnt, n_compared);
      if (error_cnt == 0 && n_compared > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   end
   endtask
   initial
   begin
      #100000;
      error_cnt = error_cnt + 1;
      test_done;
   end
   initial
   begin
      repeat (8) @(posedge ref_clk_i);
      sys_rst_i <= 0;
      ctl = 16'hFFFF;
      bus(0, 4'h0, 16'h0000);
      chk(oe, 16'h0000);
      chk(v, 16'hFFFF);
      chk(po, 16'h0000);
      for (i = 0; i < 20; i = i + 1)
      begin
         @(posedge ref_clk_i);
         r = $random(seed);
         flg <= r[3:0];
         peer <= r[9:4];
         r = $random(seed);
         e = r[15:0];
         if (i == 2)
            e[11:8] = 4'h0;
         if (i == 4)
            e[11:8] = 4'hF;
         // Odd passes hit an unmapped index
         bus(1, i[0] ? 4'h7 : 4'h0, e);
         if (!i[0])
            ctl = e | 16'hF0C0;
         repeat (6) @(negedge ref_clk_i);
         xoe = xp(ctl, flg);
         chk(oe, xoe);
         bus(0, 4'h0, 16'h0000);
         chk(v, {ctl[15:6], ~(xoe | peer)});
         bus(0, 4'h1, 16'h0000);
         chk(v, {4'h0, flg, 8'h00});
         bus(0, 4'h7, 16'h0000);
         chk(v, 16'h0000);
         chk(irq, 16'h0000);
      end
      // Second reset in mid-run
      @(posedge ref_clk_i);
      sys_rst_i <= 1;
      peer <= 6'h00;
      repeat (3) @(posedge ref_clk_i);
      sys_rst_i <= 0;
      bus(0, 4'h0, 16'h0000);
      chk(v, 16'hFFFF);
      chk(oe, 16'h0000);
      bus(1, 4'h3, 16'h0005);
      @(posedge ref_clk_i);
      flg <= 4'h0;
      bus(0, 4'h2, 16'h0000);
      @(posedge ref_clk_i);
      flg <= 4'hF;
      repeat (3) @(negedge ref_clk_i);
      chk(irq, 16'h0001);
      bus(0, 4'h2, 16'h0000);
      chk(v, 16'h000F);
      repeat (3) @(negedge ref_clk_i);
      chk(irq, 16'h0000);
      test_done;
   end
endmodule

// ---- gapc_sync3.v ----
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module gapc_sync3 #(
   parameter W = 6
)(
   // Clock and reset
   input wire ref_clk_i,
   input wire sys_rst_i,
   // Data
   input wire [W-1:0] async_i,
   output wire [W-1:0] sync_o
);
   reg [W-1:0] s1_ff;
   reg [W-1:0] s2_ff;
   reg [W-1:0] s3_ff;
   reg [W-1:0] out_ff;
   wire [W-1:0] nxt_out;

   // Change accepted once stages two and three agree
   assign nxt_out = (s2_ff == s3_ff) ? s3_ff : out_ff;

   always @(posedge ref_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         s1_ff <= {W{1'b1}};
         s2_ff <= {W{1'b1}};
         s3_ff <= {W{1'b1}};
         out_ff <= {W{1'b1}};
      end
      else
      begin
         s1_ff <= async_i;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         out_ff <= nxt_out;
      end
   end

   assign sync_o = out_ff;
endmodule
